//--- lce_cfg.svh
// constants for the legacy letter command executor
`ifndef LCE_CFG_SVH
`define LCE_CFG_SVH
// ====================================
// status byte bit positions
`define LCE_BIT_OVL 0
`define LCE_BIT_RDY 4
`define LCE_BIT_ERR 5
`define LCE_BIT_SVC 6
// ====================================
// service mask bit positions and reset value
`define LCE_MASK_OVL 0
`define LCE_MASK_RDY 4
`define LCE_MASK_RST 8'h00
// ====================================
// header letters
`define LCE_LTR_M 8'h4d
`define LCE_LTR_K 8'h4b
`define LCE_LTR_A 8'h41
`define LCE_LTR_I 8'h49
`define LCE_LTR_R 8'h52
`define LCE_LTR_T 8'h54
`define LCE_LTR_P 8'h50
`define LCE_LTR_Z 8'h5a
`define LCE_LTR_S 8'h53
`define LCE_LTR_N 8'h4e
`define LCE_LTR_C 8'h43
`define LCE_LTR_Y 8'h59
`define LCE_LTR_U 8'h55
`define LCE_LTR_L 8'h4c
`define LCE_LTR_X 8'h58
// ====================================
// execution priorities, 1 is highest
`define LCE_PRIO_NONE 4'h0
`define LCE_PRIO_M 4'h1
`define LCE_PRIO_K 4'h2
`define LCE_PRIO_A 4'h3
`define LCE_PRIO_I 4'h4
`define LCE_PRIO_R 4'h5
`define LCE_PRIO_T 4'h6
`define LCE_PRIO_P 4'h7
`define LCE_PRIO_Z 4'h8
`define LCE_PRIO_S 4'h9
`define LCE_PRIO_NSW 4'ha
`define LCE_PRIO_C 4'hb
`define LCE_PRIO_NAUTO 4'hc
`define LCE_PRIO_Y 4'hd
`define LCE_PRIO_U 4'he
`define LCE_PRIO_L 4'hf
// ====================================
// parameters and defaults
`define LCE_N_AUTO_PARAM 8'h02
`define LCE_DEF_A 8'h01
`define LCE_DEF_C 8'h01
`define LCE_DEF_I 8'h00
`define LCE_DEF_K 8'h00
`define LCE_DEF_OTHER 8'h00
`define LCE_MAX_PARAMS 2'h2
`define LCE_K_HOLD_MAX 8'h01
`define LCE_BUF_DEPTH 16
`endif

//--- lce_pkg.sv
// types of the legacy letter command executor
package lce_pkg;
  // ====================================
  // sequencer states, gray along idle-scan-done
  typedef enum logic [1:0] {
    LCE_IDLE = 2'b00,
    LCE_SCAN = 2'b01,
    LCE_DONE = 2'b11,
    LCE_DISCARD = 2'b10
  } lce_state_t;
  // ====================================
  // one buffered command
  typedef struct packed {
    logic [3:0] prio;
    logic [7:0] letter;
    logic [7:0] p0;
    logic [7:0] p1;
  } lce_entry_t;
endpackage : lce_pkg

//--- lce_buf_if.sv
// command buffer port between sequencer and memory
interface lce_buf_if #(parameter int AW = 4, parameter int DW = 28) ();
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [DW-1:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [DW-1:0] rdData;
  modport ctrl(output wrEn, output wrAddr, output wrData, output rdAddr,
    input rdData);
  modport mem(input wrEn, input wrAddr, input wrData, input rdAddr,
    output rdData);
endinterface : lce_buf_if

//--- lce_cmd_mem.sv
// command buffer memory with registered read
module lce_cmd_mem #(parameter int DEPTH = 16) (
  input wire logic ref_clk,
  lce_buf_if.mem bus
);
  logic [$bits(bus.wrData)-1:0] mem [DEPTH];
  // ====================================
  // storage
  always_ff @(posedge ref_clk) begin
    if (bus.wrEn) begin
      mem[bus.wrAddr] <= bus.wrData;
    end
    bus.rdData <= mem[bus.rdAddr];
  end
endmodule : lce_cmd_mem

//--- lce_status.sv
// polled status byte and service request
`include "lce_cfg.svh"
module lce_status import lce_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic legacyMode,
  input wire logic gpibActive,
  input wire logic ovlSync,
  input wire logic readySet,
  input wire logic readyClr,
  input wire logic errSet,
  input wire logic errClr,
  input wire logic dclSdc,
  input wire logic pollReq,
  input wire logic [7:0] mask,
  output logic [7:0] statusByte,
  output logic [7:0] pollData,
  output logic pollValid,
  output logic srqOut
);
  logic svcFlag;
  logic err;
  logic rdy;
  logic ovlPrev;
  logic rdyPrev;
  // ====================================
  // decode
  wire pollTake = pollReq && gpibActive;
  wire ovlRise = ovlSync && !ovlPrev;
  wire rdyRise = rdy && !rdyPrev;
  wire srqEvent = legacyMode && gpibActive &&
    ((ovlRise && mask[`LCE_MASK_OVL]) || (rdyRise && mask[`LCE_MASK_RDY]));
  wire next_svcFlag = srqEvent || (svcFlag && !(dclSdc || pollTake));
  wire next_err = errSet || (err && !errClr);
  wire next_rdy = readySet || (rdy && !readyClr);
  // unused bits tied low
  assign statusByte = {1'b0, svcFlag, err, rdy, 3'b000, ovlSync};
  assign srqOut = svcFlag;
  // ====================================
  // flags, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      svcFlag <= 1'b0;
      err <= 1'b0;
      rdy <= 1'b0;
      ovlPrev <= 1'b0;
      rdyPrev <= 1'b0;
    end else begin
      svcFlag <= next_svcFlag;
      err <= next_err;
      rdy <= next_rdy;
      ovlPrev <= ovlSync;
      rdyPrev <= rdy;
    end
  end
  // poll answer only on the gpib side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pollData <= 8'h00;
      pollValid <= 1'b0;
    end else begin
      pollValid <= pollTake;
      if (pollTake) begin
        pollData <= statusByte;
      end
    end
  end
  // ====================================
  // checks
  a_unused_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pollValid |-> (pollData & 8'h8e) == 8'h00)
    else $error("unused status bits nonzero");
  a_svc_gpib_only: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !gpibActive && !svcFlag |=> !svcFlag)
    else $error("service request set off gpib");
  a_svc_poll_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pollTake && !srqEvent |=> !svcFlag)
    else $error("service flag survived poll");
  a_err_held: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    err && !errClr |=> err)
    else $error("error bit dropped early");
  a_ovl_polled: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    pollTake |=> pollData[`LCE_BIT_OVL] == $past(ovlSync))
    else $error("overload bit wrong in poll");
  a_ready_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    readyClr && !readySet |=> !rdy)
    else $error("ready bit kept after execute");
  a_mask_gates: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(svcFlag) |-> $past(mask[`LCE_MASK_OVL] || mask[`LCE_MASK_RDY]))
    else $error("service request without mask");
endmodule : lce_status

//--- lce_executor.sv
// legacy letter command executor top
// Notes on behaviour
// - legacy commands only taken when legacy mode selected; else dropped.
// - status byte answers only a gpib serial poll.
// - status bits 7, 3, 2, 1 always read zero.
// - request-service flag set on request; cleared by device clear or poll.
// - error bit set on error; cleared after error-status query answered.
// - ready bit set when ready; cleared when execute arrives.
// - overload bit follows the overload condition.
// - service requests only on gpib, never via usb.
// - letter plus zero to two parameters; missing ones get defaults.
// - commands buffered in arrival order until execute.
// - execute runs buffer in fixed priority order, arrival order within.
// - any header or parameter error discards the whole batch.
// - with hold-off, NRFD held from execute until batch finished.
// - mask bit0 enables overload request, bit4 ready request.
`include "lce_cfg.svh"
module lce_executor import lce_pkg::*; #(
  parameter int DEPTH = `LCE_BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic legacyMode,
  input wire logic gpibActive,
  input wire logic overloadPin,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdLetter,
  input wire logic [1:0] cmdParamCount,
  input wire logic [7:0] cmdParam0,
  input wire logic [7:0] cmdParam1,
  input wire logic cmdParamErr,
  output logic execValid,
  output logic [7:0] execLetter,
  output logic [7:0] execParam0,
  output logic [7:0] execParam1,
  input wire logic execErr,
  input wire logic errQueryDone,
  input wire logic dclSdc,
  input wire logic pollReq,
  output logic [7:0] pollData,
  output logic pollValid,
  output logic srqOut,
  output logic nrfdHold
);
  localparam int IW = $clog2(DEPTH);
  localparam logic [IW:0] FULL = (IW+1)'(DEPTH);
  // ====================================
  // helpers
  function automatic logic [3:0] lcePrio(input logic [7:0] l,
      input logic [7:0] p);
    case (l)
      `LCE_LTR_M: lcePrio = `LCE_PRIO_M;
      `LCE_LTR_K: lcePrio = `LCE_PRIO_K;
      `LCE_LTR_A: lcePrio = `LCE_PRIO_A;
      `LCE_LTR_I: lcePrio = `LCE_PRIO_I;
      `LCE_LTR_R: lcePrio = `LCE_PRIO_R;
      `LCE_LTR_T: lcePrio = `LCE_PRIO_T;
      `LCE_LTR_P: lcePrio = `LCE_PRIO_P;
      `LCE_LTR_Z: lcePrio = `LCE_PRIO_Z;
      `LCE_LTR_S: lcePrio = `LCE_PRIO_S;
      `LCE_LTR_N: lcePrio = (p == `LCE_N_AUTO_PARAM) ? `LCE_PRIO_NAUTO :
        `LCE_PRIO_NSW;
      `LCE_LTR_C: lcePrio = `LCE_PRIO_C;
      `LCE_LTR_Y: lcePrio = `LCE_PRIO_Y;
      `LCE_LTR_U: lcePrio = `LCE_PRIO_U;
      `LCE_LTR_L: lcePrio = `LCE_PRIO_L;
      default: lcePrio = `LCE_PRIO_NONE;
    endcase
  endfunction : lcePrio
  function automatic logic [7:0] lceDefault(input logic [7:0] l);
    case (l)
      `LCE_LTR_A: lceDefault = `LCE_DEF_A;
      `LCE_LTR_C: lceDefault = `LCE_DEF_C;
      `LCE_LTR_I: lceDefault = `LCE_DEF_I;
      `LCE_LTR_K: lceDefault = `LCE_DEF_K;
      default: lceDefault = `LCE_DEF_OTHER;
    endcase
  endfunction : lceDefault
  // ====================================
  // state
  lce_state_t state;
  lce_state_t next_state;
  logic [IW:0] count;
  logic batchErr;
  logic [3:0] scanPrio;
  logic [IW-1:0] scanIdx;
  logic [3:0] chkPrio;
  logic chkValid;
  logic [7:0] mask;
  logic holdOff;
  logic ovlMeta;
  logic ovlSync;
  lce_entry_t wrEntry;
  lce_entry_t rdEntry;
  lce_buf_if #(.AW(IW), .DW($bits(lce_entry_t))) buf_bus ();
  // ====================================
  // intake decode
  wire idle = (state == LCE_IDLE);
  assign cmdReady = idle;
  wire take = cmdValid && cmdReady;
  wire takeLegacy = take && legacyMode;
  wire isExec = (cmdLetter == `LCE_LTR_X);
  wire [7:0] p0Fill = (cmdParamCount != 2'h0) ? cmdParam0 :
    lceDefault(cmdLetter);
  wire [7:0] p1Fill = (cmdParamCount == `LCE_MAX_PARAMS) ? cmdParam1 :
    `LCE_DEF_OTHER;
  wire [3:0] newPrio = lcePrio(cmdLetter, p0Fill);
  wire badCmd = (newPrio == `LCE_PRIO_NONE) || cmdParamErr ||
    (cmdParamCount > `LCE_MAX_PARAMS) || (count == FULL);
  wire execTake = takeLegacy && isExec;
  wire storeTake = takeLegacy && !isExec && !badCmd;
  assign wrEntry = '{prio: newPrio, letter: cmdLetter, p0: p0Fill,
    p1: p1Fill};
  assign buf_bus.wrEn = storeTake;
  assign buf_bus.wrAddr = count[IW-1:0];
  assign buf_bus.wrData = wrEntry;
  assign buf_bus.rdAddr = scanIdx;
  assign rdEntry = buf_bus.rdData;
  // ====================================
  // scan decode, priority outer, arrival order inner
  wire lastIdx = ({1'b0, scanIdx} == (IW+1)'(count - 1'b1));
  wire lastIssue = lastIdx && (scanPrio == `LCE_PRIO_L);
  wire hit = chkValid && (rdEntry.prio == chkPrio);
  wire batchEnd = (state == LCE_DONE) || (state == LCE_DISCARD);
  always_comb begin
    next_state = state;
    unique case (state)
      LCE_IDLE: begin
        if (execTake) begin
          if (batchErr || (badCmd && !isExec)) begin
            next_state = LCE_DISCARD;
          end else if (count == '0) begin
            next_state = LCE_DONE;
          end else begin
            next_state = LCE_SCAN;
          end
        end
      end
      LCE_SCAN: begin
        if (lastIssue) begin
          next_state = LCE_DONE;
        end
      end
      LCE_DONE: next_state = LCE_IDLE;
      LCE_DISCARD: next_state = LCE_IDLE;
    endcase
  end
  // ====================================
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= LCE_IDLE;
      count <= '0;
      batchErr <= 1'b0;
    end else begin
      state <= next_state;
      if (batchEnd) begin
        count <= '0;
        batchErr <= 1'b0;
      end else if (storeTake) begin
        count <= count + 1'b1;
      end else if (takeLegacy && !isExec && badCmd) begin
        batchErr <= 1'b1;
      end
    end
  end
  // scan counters
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scanPrio <= `LCE_PRIO_M;
      scanIdx <= '0;
      chkPrio <= `LCE_PRIO_NONE;
      chkValid <= 1'b0;
    end else begin
      chkValid <= (state == LCE_SCAN);
      chkPrio <= scanPrio;
      if (state != LCE_SCAN) begin
        scanPrio <= `LCE_PRIO_M;
        scanIdx <= '0;
      end else if (lastIdx) begin
        scanPrio <= scanPrio + 1'b1;
        scanIdx <= '0;
      end else begin
        scanIdx <= scanIdx + 1'b1;
      end
    end
  end
  // ====================================
  // execution output and local settings
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      execValid <= 1'b0;
      execLetter <= 8'h00;
      execParam0 <= 8'h00;
      execParam1 <= 8'h00;
      mask <= `LCE_MASK_RST;
      holdOff <= 1'b1;
    end else begin
      execValid <= hit;
      if (hit) begin
        execLetter <= rdEntry.letter;
        execParam0 <= rdEntry.p0;
        execParam1 <= rdEntry.p1;
        if (rdEntry.letter == `LCE_LTR_M) begin
          mask <= rdEntry.p0;
        end
        if (rdEntry.letter == `LCE_LTR_K) begin
          holdOff <= (rdEntry.p0 <= `LCE_K_HOLD_MAX);
        end
      end
    end
  end
  // hold the bus until the batch has run, gpib only
  assign nrfdHold = holdOff && gpibActive && legacyMode && !idle;
  // ====================================
  // overload pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovlMeta <= 1'b0;
      ovlSync <= 1'b0;
    end else begin
      ovlMeta <= overloadPin;
      ovlSync <= ovlMeta;
    end
  end
  // ====================================
  // sub blocks
  lce_cmd_mem #(.DEPTH(DEPTH)) u_mem (
    .ref_clk(ref_clk),
    .bus(buf_bus.mem)
  );
  lce_status u_status (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .legacyMode(legacyMode),
    .gpibActive(gpibActive),
    .ovlSync(ovlSync),
    .readySet(batchEnd || (idle && legacyMode && !execTake)),
    .readyClr(execTake),
    .errSet((state == LCE_DISCARD) || execErr),
    .errClr(errQueryDone),
    .dclSdc(dclSdc),
    .pollReq(pollReq),
    .mask(mask),
    .statusByte(),
    .pollData(pollData),
    .pollValid(pollValid),
    .srqOut(srqOut)
  );
  // ====================================
  // checks
  a_native_drop: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !legacyMode |-> !buf_bus.wrEn)
    else $error("native mode wrote buffer");
  a_discard_silent: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state == LCE_DISCARD |-> !execValid ##1 !execValid)
    else $error("discarded batch executed");
  a_bad_flagged: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    takeLegacy && !isExec && badCmd |=> batchErr)
    else $error("bad command not flagged");
  a_buffer_empties: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    batchEnd |=> count == '0 && idle)
    else $error("buffer not emptied");
  a_holdoff_bus: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    execTake && holdOff && gpibActive |=> nrfdHold)
    else $error("nrfd not held");
  a_exec_order: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    hit && $past(hit) |-> rdEntry.prio >= $past(rdEntry.prio))
    else $error("priority order broken");
  a_busy_stall: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    execTake |=> !cmdReady)
    else $error("intake open while busy");
endmodule : lce_executor

//--- lce_host_model.sv
// host side model: gpib controller sending letter commands and polls
module lce_host_model (
  input wire logic ref_clk,
  input wire logic cmdReady,
  input wire logic pollValid,
  input wire logic [7:0] pollData,
  output logic cmdValid,
  output logic [7:0] cmdLetter,
  output logic [1:0] cmdParamCount,
  output logic [7:0] cmdParam0,
  output logic [7:0] cmdParam1,
  output logic pollReq,
  output logic dclSdc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmdValid = 1'b0;
    cmdLetter = 8'h00;
    cmdParamCount = 2'h0;
    cmdParam0 = 8'h00;
    cmdParam1 = 8'h00;
    pollReq = 1'b0;
    dclSdc = 1'b0;
  end
  // ====================================
  // commands
  // one header letter and zero to two params, held until taken
  task automatic send(input logic [7:0] ltr, input logic [1:0] cnt,
      input logic [7:0] a, input logic [7:0] b = 8'h00);
    int n;
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdLetter = ltr;
    cmdParamCount = cnt;
    cmdParam0 = a;
    cmdParam1 = b;
    n = 0;
    @(posedge ref_clk);
    while (cmdReady !== 1'b1 && n < 500) begin
      n++;
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    cmdValid = 1'b0;
    // released lines must not keep looking like the last command
    cmdLetter = ~cmdLetter;
    cmdParam0 = ~cmdParam0;
    cmdParam1 = ~cmdParam1;
  endtask : send
  // a lone command closed by its own execute keeps the sent order
  task automatic send_one(input logic [7:0] ltr, input logic [7:0] a);
    send(ltr, 2'h1, a);
    send(8'h58, 2'h0, 8'h00);
  endtask : send_one
  // ====================================
  // serial poll and device clear
  task automatic poll(output logic [7:0] d, output logic got);
    @(negedge ref_clk);
    pollReq = 1'b1;
    @(negedge ref_clk);
    pollReq = 1'b0;
    got = pollValid;
    d = pollData;
  endtask : poll
  task automatic devclr;
    @(negedge ref_clk);
    dclSdc = 1'b1;
    @(negedge ref_clk);
    dclSdc = 1'b0;
  endtask : devclr
endmodule : lce_host_model

//--- test_lce_executor.sv
// self-checking bench for the legacy letter command executor
`define LCE_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_lce_executor;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst_n, legacyMode, gpibActive, overloadPin;
  logic cmdValid, cmdReady, cmdParamErr, execValid, execErr;
  logic [7:0] cmdLetter, cmdParam0, cmdParam1, pollData;
  logic [7:0] execLetter, execParam0, execParam1;
  logic [1:0] cmdParamCount;
  logic errQueryDone, dclSdc, pollReq, pollValid, srqOut, nrfdHold;
  logic [23:0] execLog[$];
  logic [7:0] pd;
  logic got;
  int miscompares = 0;
  int cmp_count = 0;
  // ====================================
  // clock, design and host
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  lce_executor #(.DEPTH(16)) lce_executor_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .legacyMode(legacyMode), .gpibActive(gpibActive),
    .overloadPin(overloadPin), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdLetter(cmdLetter), .cmdParamCount(cmdParamCount),
    .cmdParam0(cmdParam0), .cmdParam1(cmdParam1),
    .cmdParamErr(cmdParamErr), .execValid(execValid),
    .execLetter(execLetter), .execParam0(execParam0),
    .execParam1(execParam1), .execErr(execErr),
    .errQueryDone(errQueryDone), .dclSdc(dclSdc), .pollReq(pollReq),
    .pollData(pollData), .pollValid(pollValid), .srqOut(srqOut),
    .nrfdHold(nrfdHold));
  lce_host_model lce_host_model_i (.ref_clk(ref_clk), .cmdReady(cmdReady),
    .pollValid(pollValid), .pollData(pollData), .cmdValid(cmdValid),
    .cmdLetter(cmdLetter), .cmdParamCount(cmdParamCount),
    .cmdParam0(cmdParam0), .cmdParam1(cmdParam1), .pollReq(pollReq),
    .dclSdc(dclSdc));
  always @(posedge ref_clk) begin
    if (execValid === 1'b1) begin
      execLog.push_back({execLetter, execParam0, execParam1});
    end
  end
  // ====================================
  // helpers
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmdReady !== 1'b1 && n < 400) begin
      n++;
      @(negedge ref_clk);
    end
  endtask : wait_idle
  task automatic clear_err;
    @(negedge ref_clk);
    errQueryDone = 1'b1;
    @(negedge ref_clk);
    errQueryDone = 1'b0;
  endtask : clear_err
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // ====================================
  // scenarios
  task automatic t_reset;
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("poll answer", 1'b1, got)
    `LCE_CHK("idle status", 8'h10, pd)
    $display("test reset done");
  endtask : t_reset
  // batch sent low priority first must run high priority first
  task automatic t_order;
    execLog.delete();
    lce_host_model_i.send(8'h4c, 2'h0, 8'h00);
    lce_host_model_i.send(8'h4e, 2'h1, 8'h02);
    lce_host_model_i.send(8'h41, 2'h0, 8'h00);
    lce_host_model_i.send(8'h43, 2'h0, 8'h00);
    lce_host_model_i.send(8'h4d, 2'h1, 8'h11);
    lce_host_model_i.send(8'h52, 2'h2, 8'h05, 8'h07);
    lce_host_model_i.send(8'h58, 2'h0, 8'h00);
    `LCE_CHK("nrfd hold", 1'b1, nrfdHold)
    `LCE_CHK("intake closed", 1'b0, cmdReady)
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("busy ready bit", 1'b0, pd[4])
    wait_idle();
    `LCE_CHK("exec count", 6, execLog.size())
    `LCE_CHK("first", 24'h4d1100, execLog[0])
    `LCE_CHK("second", 24'h410100, execLog[1])
    `LCE_CHK("third", 24'h520507, execLog[2])
    `LCE_CHK("fourth", 24'h430100, execLog[3])
    `LCE_CHK("fifth", 24'h4e0200, execLog[4])
    `LCE_CHK("sixth", 24'h4c0000, execLog[5])
    repeat (3) @(negedge ref_clk);
    `LCE_CHK("ready request", 1'b1, srqOut)
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("status", 8'h50, pd)
    `LCE_CHK("service flag after poll", 1'b0, srqOut)
    $display("test order done");
  endtask : t_order
  // a bad header drops the whole batch, then the buffer starts empty
  task automatic t_discard;
    execLog.delete();
    lce_host_model_i.send(8'h42, 2'h0, 8'h00);
    lce_host_model_i.send(8'h41, 2'h1, 8'h03);
    lce_host_model_i.send(8'h58, 2'h0, 8'h00);
    wait_idle();
    `LCE_CHK("discarded", 0, execLog.size())
    repeat (3) @(negedge ref_clk);
    lce_host_model_i.devclr();
    `LCE_CHK("flag after clear", 1'b0, srqOut)
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("error status", 8'h30, pd)
    clear_err();
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("error cleared", 8'h10, pd)
    lce_host_model_i.send_one(8'h41, 8'h02);
    wait_idle();
    `LCE_CHK("next batch", 1, execLog.size())
    `LCE_CHK("next entry", 24'h410200, execLog[0])
    cmdParamErr = 1'b1;
    lce_host_model_i.send(8'h41, 2'h1, 8'h05);
    cmdParamErr = 1'b0;
    lce_host_model_i.send(8'h58, 2'h0, 8'h00);
    wait_idle();
    `LCE_CHK("param error batch", 1, execLog.size())
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("param error status", 8'h70, pd)
    clear_err();
    lce_host_model_i.devclr();
    $display("test discard done");
  endtask : t_discard
  // with hold-off disabled the bus is never held; K0 brings it back
  task automatic t_holdoff;
    lce_host_model_i.send_one(8'h4b, 8'h02);
    wait_idle();
    lce_host_model_i.send_one(8'h49, 8'h01);
    `LCE_CHK("hold off", 1'b0, nrfdHold)
    wait_idle();
    lce_host_model_i.send_one(8'h4b, 8'h00);
    wait_idle();
    lce_host_model_i.send_one(8'h49, 8'h00);
    `LCE_CHK("hold on", 1'b1, nrfdHold)
    wait_idle();
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("holdoff status", 8'h50, pd)
    $display("test holdoff done");
  endtask : t_holdoff
  task automatic t_overload;
    overloadPin = 1'b1;
    repeat (4) @(negedge ref_clk);
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("overload", 8'h51, pd)
    overloadPin = 1'b0;
    repeat (4) @(negedge ref_clk);
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("overload gone", 8'h10, pd)
    $display("test overload done");
  endtask : t_overload
  // off the gpib there is no poll and no service request
  task automatic t_usb;
    gpibActive = 1'b0;
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("usb poll", 1'b0, got)
    overloadPin = 1'b1;
    repeat (4) @(negedge ref_clk);
    `LCE_CHK("usb srq", 1'b0, srqOut)
    overloadPin = 1'b0;
    repeat (4) @(negedge ref_clk);
    gpibActive = 1'b1;
    lce_host_model_i.poll(pd, got);
    `LCE_CHK("no service flag", 8'h10, pd)
    $display("test usb done");
  endtask : t_usb
  task automatic t_native;
    execLog.delete();
    legacyMode = 1'b0;
    lce_host_model_i.send_one(8'h41, 8'h03);
    repeat (40) @(negedge ref_clk);
    `LCE_CHK("native drop", 0, execLog.size())
    $display("test native done");
  endtask : t_native
  // ====================================
  // main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    legacyMode = 1'b1;
    gpibActive = 1'b1;
    overloadPin = 1'b0;
    cmdParamErr = 1'b0;
    execErr = 1'b0;
    errQueryDone = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_order();
    t_discard();
    t_holdoff();
    t_overload();
    t_usb();
    t_native();
    final_report();
  end
  initial begin
    #50000;
    miscompares++;
    final_report();
  end
endmodule : test_lce_executor
